// File: core/gds_pkg.sv
// Constants, types and lookup functions of the gate driver supervision block
package gds_pkg;
    // Clock rate and times in their own units
    localparam int CLK_MHZ = 200;
    localparam int T_CLEAR_NS = 3000;
    localparam int T_OVL_NS = 4000;
    localparam int T_EXT_NS = 10000;
    localparam int T_RT_NS = 1000;
    localparam int T_DLY_UNIT_NS = 1000;
    localparam int T_WD_BASE_MS = 1;
    localparam int T_CFG_MS = 100;
    localparam int T_PFB_MS = 50;
    // Derived cycle counts
    localparam int CLEAR_CYC = (T_CLEAR_NS * CLK_MHZ + 999) / 1000;
    localparam int OVL_CYC = (T_OVL_NS * CLK_MHZ + 999) / 1000;
    localparam int EXT_CYC = (T_EXT_NS * CLK_MHZ + 999) / 1000;
    localparam int RT_CYC = T_RT_NS * CLK_MHZ / 1000;
    localparam int DLY_UNIT_CYC = T_DLY_UNIT_NS * CLK_MHZ / 1000;
    localparam int WD_BASE_CYC = T_WD_BASE_MS * CLK_MHZ * 1000;
    localparam int CFG_CYC = T_CFG_MS * CLK_MHZ * 1000;
    localparam int PFB_CYC = T_PFB_MS * CLK_MHZ * 1000;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SVC = 8'h04;
    localparam logic [7:0] ADDR_SIG = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_SER = 8'h10;
    // Control register fields
    localparam int F_WDPER = 0;
    localparam int F_WDRAT = 2;
    localparam int F_WDLOOP = 5;
    localparam int F_PFB = 8;
    localparam int F_APCWD = 9;
    localparam int F_APCVCC = 10;
    localparam int F_APCINV = 11;
    localparam int F_APCDLY = 12;
    localparam int F_BEH = 16;
    localparam logic [31:0] CTRL_RST = 32'h0015_0000;
    localparam logic [7:0] SIG_OK = 8'h5a;
    localparam int SER_APC = 3;
    // Fault behaviour codes per supervision
    localparam logic [1:0] BEH_WARN = 2'h0;
    localparam logic [1:0] BEH_LATCH = 2'h1;
    localparam logic [1:0] BEH_ARE = 2'h2;
    localparam logic [1:0] BEH_ERR = 2'h3;
    // Threshold percentages of the phase comparator
    localparam logic [6:0] PFB_HI0 = 7'd80;
    localparam logic [6:0] PFB_LO0 = 7'd25;
    localparam logic [6:0] PFB_HI1 = 7'd50;
    localparam logic [6:0] PFB_LO1 = 7'd50;

    typedef enum logic [2:0] {
        MODE_IDLE, MODE_CONFIG, MODE_NORMAL, MODE_ERROR, MODE_LOCK
    } gds_mode_t;
    typedef enum logic [1:0] {APC_IDLE, APC_DELAY, APC_ACTIVE} gds_apc_t;

    // Watchdog period multiple of the base step
    function automatic logic [3:0] wdMult(input logic [1:0] s);
        case (s)
            2'h0: return 4'h1;
            2'h1: return 4'h2;
            2'h2: return 4'h5;
            default: return 4'ha;
        endcase
    endfunction : wdMult

    // Closed window share of the period in percent
    function automatic logic [6:0] wdRatio(input logic [2:0] s);
        case (s)
            3'h0: return 7'd50;
            3'h1: return 7'd55;
            3'h2: return 7'd60;
            3'h3: return 7'd70;
            3'h4: return 7'd75;
            3'h5: return 7'd80;
            3'h6: return 7'd90;
            default: return 7'd95;
        endcase
    endfunction : wdRatio
endpackage : gds_pkg

// File: core/gds_hold.sv
// Persistence filter: reports a level held for a number of cycles
`timescale 1ns/1ps
`default_nettype none
module gds_hold #(
    parameter int N = 2
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic level,
    output logic held,
    output logic hit
);
    logic [15:0] cntQ;
    logic [15:0] cntD;

    // Count while high, saturate at the threshold
    always_comb begin
        if (!level) begin
            cntD = 16'h0;
        end else if (cntQ == 16'(N)) begin
            cntD = cntQ;
        end else begin
            cntD = cntQ + 16'h1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cntQ <= 16'h0;
        end else begin
            cntQ <= cntD;
        end
    end

    // Hit pulses once, in the cycle the threshold is reached
    assign held = (cntQ == 16'(N));
    assign hit = level && (cntQ == 16'(N - 1));
endmodule : gds_hold
`default_nettype wire

// File: core/gds_wwd.sv
// Window watchdog with loop counter
`timescale 1ns/1ps
`default_nettype none
module gds_wwd (
    input wire logic clk,
    input wire logic rstN,
    input wire logic en,
    input wire logic svc,
    input wire logic [31:0] periodCyc,
    input wire logic [31:0] closedCyc,
    input wire logic [4:0] limit,
    output logic failEvt,
    output logic wdErr,
    output logic [4:0] loopCnt
);
    logic [31:0] cntQ;
    logic [31:0] cntD;
    logic [4:0] lcQ;
    logic [4:0] lcD;
    logic failQ;
    logic failD;

    // Early service or missing service both fail
    always_comb begin
        cntD = cntQ + 32'h1;
        failD = 1'b0;
        lcD = lcQ;
        // Loop count restarts whenever the watchdog is off, so no stale error survives
        if (!en) begin
            cntD = 32'h0;
            lcD = 5'h0;
        end else if (svc || cntQ >= periodCyc - 32'h1) begin
            cntD = 32'h0;
            failD = !svc || (cntQ < closedCyc);
        end
        if (en && failD && lcQ < limit) begin
            lcD = lcQ + 5'h1;
        end else if (en && svc && !failD && lcQ != 5'h0 && lcQ < limit) begin
            lcD = lcQ - 5'h1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cntQ <= 32'h0;
            lcQ <= 5'h0;
            failQ <= 1'b0;
        end else begin
            cntQ <= cntD;
            lcQ <= lcD;
            failQ <= failD;
        end
    end

    assign failEvt = failQ;
    assign wdErr = (lcQ >= limit);
    assign loopCnt = lcQ;

    early_svc_a: assert property (@(posedge clk) disable iff (!rstN)
        en && svc && cntQ < closedCyc |=> failEvt)
        else $error("early service not flagged");
endmodule : gds_wwd
`default_nettype wire

// File: core/gds_supervisor.sv
// Supervision, fault control and phase cut-off of the bridge driver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Watchdog period selectable in four steps from 1 ms to 10 ms.
// - Closed window share selectable in eight steps, 50 to 95 percent.
// - Watchdog loop counter limit selectable in eight steps, 2 to 16.
// - Drive-enable low for the clear threshold clears latched errors.
// - Auto-recover faults return to normal within 1 us of disappearing.
// - Fault pin indication is stretched to the 10 us extension time.
// - Output pin overload counts only after persisting about 4 us.
// - Threshold bit picks 80/25 percent (default) or 50/50 percent.
// - Woken at high bridge supply, phase levels valid after 50 ms.
// - Cut-off triggered by watchdog failure or logic supply fault, as configured.
// - Cut-off pin output characteristic is configurable.
// - Cut-off trigger sets bit 3 of the special event register.
// - Configurable activation delay runs before the cut-off pin drives.
// - Cut-off sequence runs to the end; only wake-hold low aborts it.
// - Cut-off active flag stays set until a drive-enable clear pulse.
// - A readable register shows the active operation mode.
// - Normal mode without error, drive-enable high: gate outputs follow inputs, diagnostics active.
// - Configuration timeout before valid signature locks until wake-hold reset.
// - Latched errors hold error mode until a drive-enable clear.
// - Auto-recover and fault-pin faults hold error only while present.
// - Supervisions set to warning never cause error mode.
module gds_supervisor
    import gds_pkg::*;
#(
    parameter int WD_BASE = WD_BASE_CYC,
    parameter int CFG_TIMEOUT = CFG_CYC,
    parameter int PFB_SETTLE = PFB_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic driveEnablePin,
    input wire logic wakeHoldPin,
    input wire logic bridgeSupplyRef,
    input wire logic vccFault,
    input wire logic outOverload,
    input wire logic [2:0] phaseCmp,
    input wire logic [5:0] gateIn,
    output logic [5:0] gateOut,
    output logic [2:0] phaseLevelOut,
    output logic [6:0] pfbHighPct,
    output logic [6:0] pfbLowPct,
    output logic faultPinN,
    output logic phaseCutOff
);
    localparam int NPIN = 14;

    // Reset release through two flops
    logic [1:0] rstSyncQ;
    logic rstN;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSyncQ <= 2'h0;
        end else begin
            rstSyncQ <= {rstSyncQ[0], 1'b1};
        end
    end
    assign rstN = rstSyncQ[1];

    // Two-flop synchronisers for every pin input
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] syncAQ;
    logic [NPIN-1:0] syncBQ;
    assign pinRaw = {gateIn, phaseCmp, driveEnablePin, wakeHoldPin,
                     bridgeSupplyRef, vccFault, outOverload};
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge sys_clk or negedge rstN) begin
            if (!rstN) begin
                syncAQ[i] <= 1'b0;
                syncBQ[i] <= 1'b0;
            end else begin
                syncAQ[i] <= pinRaw[i];
                syncBQ[i] <= syncAQ[i];
            end
        end
    end
    logic ovlS, vccS, bridgeS, inhS, enaS;
    logic [2:0] cmpS;
    logic [5:0] gateS;
    assign {gateS, cmpS, enaS, inhS, bridgeS, vccS, ovlS} = syncBQ;

    // Drive-enable low filter gives the clear pulse
    logic enaLowHeld;
    logic clrPulse;
    gds_hold #(.N(CLEAR_CYC)) u_clear (
        .clk(sys_clk),
        .rstN(rstN),
        .level(!enaS),
        .held(enaLowHeld),
        .hit(clrPulse)
    );

    // Overload must persist before it counts
    logic ovlFilt;
    gds_hold #(.N(OVL_CYC)) u_ovl (
        .clk(sys_clk),
        .rstN(rstN),
        .level(ovlS),
        .held(ovlFilt),
        .hit()
    );

    // APB register file; zero wait states
    logic [31:0] ctrlQ, ctrlD;
    logic [31:0] rdQ, rdD;
    logic serApcQ, serApcD;
    logic wrEn, rdSetup, hitAddr, cfgWr, svcWr, sigWr;
    gds_mode_t modeQ, modeD;
    logic [4:0] loopCnt;
    logic [2:0] latQ;
    logic errActive;
    gds_apc_t apcQ, apcD;

    assign wrEn = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;
    assign hitAddr = paddr == ADDR_CTRL || paddr == ADDR_SVC || paddr == ADDR_SIG
                     || paddr == ADDR_STAT || paddr == ADDR_SER;
    // Configuration only while idle or configuring
    assign cfgWr = wrEn && paddr == ADDR_CTRL
                   && (modeQ == MODE_IDLE || modeQ == MODE_CONFIG);
    assign svcWr = wrEn && paddr == ADDR_SVC;
    assign sigWr = wrEn && paddr == ADDR_SIG && modeQ == MODE_CONFIG;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!hitAddr
                     || (pwrite && paddr == ADDR_CTRL && !cfgWr)
                     || (pwrite && (paddr == ADDR_STAT || paddr == ADDR_SER)));

    // Read data is captured in the setup cycle
    always_comb begin
        rdD = rdQ;
        if (rdSetup) begin
            case (paddr)
                ADDR_CTRL: rdD = ctrlQ;
                ADDR_STAT: rdD = {17'h0, loopCnt, latQ, errActive,
                                  apcQ, 1'b0, modeQ};
                ADDR_SER: rdD = 32'(serApcQ) << SER_APC;
                default: rdD = 32'h0;
            endcase
        end
    end

    // Cut-off flag: trigger sets, clear pulse resets, set wins
    logic apcTrig;
    always_comb begin
        ctrlD = cfgWr ? pwdata : ctrlQ;
        serApcD = serApcQ;
        if (clrPulse) begin
            serApcD = 1'b0;
        end
        if (apcTrig) begin
            serApcD = 1'b1;
        end
        if (!inhS) begin
            ctrlD = CTRL_RST;
            serApcD = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            ctrlQ <= CTRL_RST;
            rdQ <= 32'h0;
            serApcQ <= 1'b0;
        end else begin
            ctrlQ <= ctrlD;
            rdQ <= rdD;
            serApcQ <= serApcD;
        end
    end
    assign prdata = rdQ;

    // Watchdog setup from the control fields
    logic [31:0] periodCyc, closedCyc;
    logic [4:0] loopLimit;
    logic wdFail, wdErr, wdEn;
    assign periodCyc = 32'(WD_BASE) * {28'h0, wdMult(ctrlQ[F_WDPER +: 2])};
    assign closedCyc = (periodCyc * {25'h0, wdRatio(ctrlQ[F_WDRAT +: 3])})
                       / 32'd100;
    assign loopLimit = {1'b0, ctrlQ[F_WDLOOP +: 3], 1'b0} + 5'h2;
    assign wdEn = inhS && (modeQ == MODE_NORMAL || modeQ == MODE_ERROR);

    gds_wwd u_wwd (
        .clk(sys_clk),
        .rstN(rstN),
        .en(wdEn),
        .svc(svcWr),
        .periodCyc(periodCyc),
        .closedCyc(closedCyc),
        .limit(loopLimit),
        .failEvt(wdFail),
        .wdErr(wdErr),
        .loopCnt(loopCnt)
    );

    // Per-supervision fault behaviour: overload, supply, watchdog
    logic [2:0] present, latD, active;
    logic [5:0] beh;
    assign present = {wdErr, vccS, ovlFilt};
    assign beh = ctrlQ[F_BEH +: 6];
    for (genvar s = 0; s < 3; s++) begin : g_fault
        always_comb begin
            latD[s] = latQ[s];
            if (clrPulse) begin
                latD[s] = 1'b0;
            end
            if (present[s] && beh[2*s +: 2] == BEH_LATCH) begin
                latD[s] = 1'b1;
            end
            case (beh[2*s +: 2])
                BEH_LATCH: active[s] = latQ[s];
                BEH_ARE, BEH_ERR: active[s] = present[s];
                default: active[s] = 1'b0;
            endcase
        end
        always_ff @(posedge sys_clk or negedge rstN) begin
            if (!rstN) begin
                latQ[s] <= 1'b0;
            end else begin
                latQ[s] <= inhS ? latD[s] : 1'b0;
            end
        end
    end
    assign errActive = |active;

    // Operation mode and configuration timer
    logic [31:0] cfgCntQ, cfgCntD;
    always_comb begin
        modeD = modeQ;
        cfgCntD = 32'h0;
        case (modeQ)
            MODE_IDLE: begin
                if (cfgWr) begin
                    modeD = MODE_CONFIG;
                end
            end
            MODE_CONFIG: begin
                cfgCntD = cfgCntQ + 32'h1;
                if (sigWr && pwdata[7:0] == SIG_OK) begin
                    modeD = MODE_NORMAL;
                end else if (cfgCntQ >= 32'(CFG_TIMEOUT - 1)) begin
                    modeD = MODE_LOCK;
                end
            end
            MODE_NORMAL: begin
                if (errActive) begin
                    modeD = MODE_ERROR;
                end
            end
            MODE_ERROR: begin
                if (!errActive) begin
                    modeD = MODE_NORMAL;
                end
            end
            MODE_LOCK: modeD = MODE_LOCK;
            default: modeD = MODE_IDLE;
        endcase
        if (!inhS) begin
            modeD = MODE_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            modeQ <= MODE_IDLE;
            cfgCntQ <= 32'h0;
        end else begin
            modeQ <= modeD;
            cfgCntQ <= cfgCntD;
        end
    end

    // Fault pin extension and gate outputs
    logic [15:0] extQ, extD;
    logic [5:0] gateD;
    logic faultD, faultQ;
    always_comb begin
        extD = (extQ != 16'h0) ? extQ - 16'h1 : 16'h0;
        if (errActive && extQ == 16'h0 && !faultQ) begin
            extD = 16'(EXT_CYC - 1);
        end
        faultD = errActive || extD != 16'h0 || modeQ == MODE_CONFIG
                 || modeQ == MODE_LOCK;
        gateD = 6'h0;
        if (modeQ == MODE_NORMAL && !errActive && enaS) begin
            gateD = gateS;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            extQ <= 16'h0;
            faultQ <= 1'b0;
            gateOut <= 6'h0;
        end else begin
            extQ <= extD;
            faultQ <= faultD;
            gateOut <= gateD;
        end
    end
    assign faultPinN = !faultQ;

    // Phase cut-off: trigger, delay, then hold until wake-hold low
    logic [11:0] dlyQ, dlyD;
    logic apcPinD, apcPinQ;
    assign apcTrig = inhS && apcQ == APC_IDLE
                     && ((ctrlQ[F_APCWD] && wdFail)
                     || (ctrlQ[F_APCVCC] && vccS));
    always_comb begin
        apcD = apcQ;
        dlyD = dlyQ;
        case (apcQ)
            APC_IDLE: begin
                if (apcTrig) begin
                    apcD = APC_DELAY;
                    dlyD = 12'(ctrlQ[F_APCDLY +: 4] * DLY_UNIT_CYC);
                end
            end
            APC_DELAY: begin
                if (dlyQ == 12'h0) begin
                    apcD = APC_ACTIVE;
                end else begin
                    dlyD = dlyQ - 12'h1;
                end
            end
            APC_ACTIVE: apcD = APC_ACTIVE;
            default: apcD = APC_IDLE;
        endcase
        if (!inhS) begin
            apcD = APC_IDLE;
        end
        apcPinD = (apcD == APC_ACTIVE) ^ ctrlQ[F_APCINV];
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            apcQ <= APC_IDLE;
            dlyQ <= 12'h0;
            apcPinQ <= 1'b0;
        end else begin
            apcQ <= apcD;
            dlyQ <= dlyD;
            apcPinQ <= apcPinD;
        end
    end
    assign phaseCutOff = apcPinQ;

    // Phase level outputs wait out the settle time at high bridge supply
    logic [31:0] pfbCntQ, pfbCntD;
    logic pfbValid;
    logic [2:0] phaseD;
    logic inhPrevQ;
    always_comb begin
        pfbCntD = pfbCntQ;
        if (!inhS) begin
            pfbCntD = 32'h0;
        end else if (!inhPrevQ && bridgeS) begin
            pfbCntD = 32'(PFB_SETTLE);
        end else if (pfbCntQ != 32'h0) begin
            pfbCntD = pfbCntQ - 32'h1;
        end
        pfbValid = inhS && pfbCntQ == 32'h0;
        phaseD = pfbValid ? cmpS : 3'h0;
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            pfbCntQ <= 32'h0;
            inhPrevQ <= 1'b0;
            phaseLevelOut <= 3'h0;
            pfbHighPct <= PFB_HI0;
            pfbLowPct <= PFB_LO0;
        end else begin
            pfbCntQ <= pfbCntD;
            inhPrevQ <= inhS;
            phaseLevelOut <= phaseD;
            pfbHighPct <= ctrlQ[F_PFB] ? PFB_HI1 : PFB_HI0;
            pfbLowPct <= ctrlQ[F_PFB] ? PFB_LO1 : PFB_LO0;
        end
    end

    // Checks on the supervision behaviour
    gate_follow_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        modeQ == MODE_NORMAL && !errActive && enaS |=> gateOut == $past(gateS))
        else $error("gate outputs do not follow inputs");
    ser_flag_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        apcTrig |=> serApcQ && apcQ == APC_DELAY)
        else $error("cut-off trigger not flagged");
    apc_hold_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        apcQ == APC_ACTIVE && inhS |=> apcQ == APC_ACTIVE)
        else $error("cut-off sequence left early");
    flag_stay_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        serApcQ && !clrPulse && inhS |=> serApcQ)
        else $error("cut-off flag lost without clear");
    lock_stay_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        modeQ == MODE_LOCK && inhS |=> modeQ == MODE_LOCK)
        else $error("lock mode left without wake-hold reset");
    are_return_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        modeQ == MODE_ERROR && !errActive && inhS |=> modeQ == MODE_NORMAL)
        else $error("late return to normal mode");
    ext_len_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        $rose(errActive) && extQ == 16'h0 && !faultQ |=> extQ == 16'(EXT_CYC - 1)
        ##1 !faultPinN [*8])
        else $error("fault indication not stretched");
    latch_keep_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        latQ[1] && !clrPulse && inhS |=> latQ[1])
        else $error("latched error cleared without full low time");
    warn_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstN)
        beh[5:4] == BEH_WARN && wdErr && active[1:0] == 2'h0 |-> !errActive)
        else $error("warning supervision raised error");
endmodule : gds_supervisor
`default_nettype wire

// File: dv/gds_host_model.sv
// Host side model: APB master for the supervision registers
`timescale 1ns/1ps
`default_nettype none
module gds_host_model (
    input wire logic sys_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rdData;
    logic rdErr;
    // Bus idle until the first transfer
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; request held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1); // No fixed latency; the bench timeout ends a hang
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : gds_host_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench of the supervision block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gds_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ena = 1'b1;
    logic wake = 1'b1;
    logic vcc = 1'b0;
    logic ovl = 1'b0;
    logic bridge = 1'b1;
    logic [5:0] gateIn = 6'h00;
    logic [5:0] gateOut;
    logic [2:0] phaseLevelOut;
    logic [6:0] pfbHighPct, pfbLowPct;
    logic faultPinN, phaseCutOff;
    int mismatches = 0;
    int n_tests = 0;
    // Small counts keep the run short
    gds_supervisor #(.WD_BASE(200), .CFG_TIMEOUT(1000), .PFB_SETTLE(500)) gds_supervisor_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .driveEnablePin(ena), .wakeHoldPin(wake),
        .bridgeSupplyRef(bridge), .vccFault(vcc), .outOverload(ovl), .phaseCmp(3'h5),
        .gateIn(gateIn), .gateOut(gateOut), .phaseLevelOut(phaseLevelOut),
        .pfbHighPct(pfbHighPct), .pfbLowPct(pfbLowPct), .faultPinN(faultPinN),
        .phaseCutOff(phaseCutOff));
    gds_host_model gds_host_model_i (
        .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    task automatic rd(input logic [7:0] a);
        gds_host_model_i.xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic mode(input gds_mode_t m);
        rd(ADDR_STAT);
        chk(32'(gds_host_model_i.rdData[2:0]), 32'(m));
    endtask : mode
    task automatic final_report();
        $display("tests %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // Hang guard, well beyond the expected run
    initial begin
        #100us;
        mismatches++;
        final_report();
    end
    // Main sequence
    initial begin
        cyc(4);
        arst_n <= 1'b1;
        cyc(4);
        chk(32'(pfbHighPct), 32'(PFB_HI0));
        rd(ADDR_CTRL);
        chk(gds_host_model_i.rdData, CTRL_RST);
        rd(8'h14);
        chk(32'(gds_host_model_i.rdErr), 32'h1);
        mode(MODE_IDLE);
        $display("test reset done");
        // Latched supply, auto-recover overload, warn watchdog, cut-off on supply
        gds_host_model_i.xfer(1'b1, ADDR_CTRL, 32'h0006_1500);
        cyc(2);
        chk({25'h0, pfbLowPct}, 32'(PFB_LO1));
        mode(MODE_CONFIG);
        gds_host_model_i.xfer(1'b1, ADDR_SIG, {24'h0, SIG_OK});
        gds_host_model_i.xfer(1'b1, ADDR_SVC, 32'h0);
        rd(ADDR_STAT);
        chk(32'(gds_host_model_i.rdData[14:10]), 32'h1);
        chk(32'(gds_host_model_i.rdData[2:0]), 32'(MODE_NORMAL));
        gateIn <= 6'h2a;
        cyc(6);
        chk(32'(gateOut), 32'h2a);
        $display("test normal done");
        vcc <= 1'b1;
        cyc(10);
        vcc <= 1'b0;
        rd(ADDR_SER);
        chk(32'(gds_host_model_i.rdData[SER_APC]), 32'h1);
        mode(MODE_ERROR);
        cyc(80);
        chk(32'(phaseCutOff), 32'h0);
        cyc(120);
        chk(32'(phaseCutOff), 32'h1);
        ena <= 1'b0;
        cyc(400);
        ena <= 1'b1;
        cyc(10);
        mode(MODE_ERROR);
        ena <= 1'b0;
        cyc(700);
        ena <= 1'b1;
        cyc(10);
        mode(MODE_NORMAL);
        rd(ADDR_SER);
        chk(32'(gds_host_model_i.rdData[SER_APC]), 32'h0);
        chk(32'(phaseCutOff), 32'h1);
        $display("test cutoff done");
        ovl <= 1'b1;
        cyc(700);
        ovl <= 1'b0;
        cyc(5);
        mode(MODE_NORMAL);
        ovl <= 1'b1;
        cyc(900);
        mode(MODE_ERROR);
        ovl <= 1'b0;
        cyc(200);
        mode(MODE_NORMAL);
        chk(32'(faultPinN), 32'h0);
        cyc(2100);
        chk(32'(faultPinN), 32'h1);
        $display("test overload done");
        // Wake-hold reset ends the cut-off, then a fresh wake
        wake <= 1'b0;
        cyc(5);
        chk(32'(phaseCutOff), 32'h0);
        wake <= 1'b1;
        cyc(200);
        chk(32'(phaseLevelOut), 32'h0);
        cyc(400);
        chk(32'(phaseLevelOut), 32'h5);
        gds_host_model_i.xfer(1'b1, ADDR_CTRL, 32'h0);
        cyc(1100);
        mode(MODE_LOCK);
        // Quiet bridge wake, then inverted cut-off pin on a missed service
        bridge <= 1'b0;
        wake <= 1'b0;
        cyc(5);
        wake <= 1'b1;
        cyc(10);
        chk(32'(phaseLevelOut), 32'h5);
        gds_host_model_i.xfer(1'b1, ADDR_CTRL, 32'h0000_0a01);
        cyc(2);
        chk(32'(phaseCutOff), 32'h1);
        gds_host_model_i.xfer(1'b1, ADDR_SIG, {24'h0, SIG_OK});
        cyc(300);
        chk(32'(phaseCutOff), 32'h1);
        cyc(110);
        chk(32'(phaseCutOff), 32'h0);
        $display("test wake done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
